//--- src/bhp_port.v
`timescale 1ns/1ps
`default_nettype none
`include "bhp_map.vh"

// write-word fifo: holds words bound for ram until the ram side takes them
module bhp_fifo #(
    parameter WIDTH = 39,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wptr_reg;
    reg [AW:0]      rptr_reg;
    wire            full  = (wptr_reg[AW] != rptr_reg[AW]) &&
                            (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    wire            empty = (wptr_reg == rptr_reg);

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rptr_reg[AW-1:0]];

    // storage write
    always @(posedge clk) begin
        if (in_valid && !full)
            mem[wptr_reg[AW-1:0]] <= in_data;
    end

    // pointers
    always @(posedge clk) begin
        if (!rst_n) begin
            wptr_reg <= {(AW+1){1'b0}};
            rptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full)
                wptr_reg <= wptr_reg + 1'b1;
            if (out_ready && !empty)
                rptr_reg <= rptr_reg + 1'b1;
        end
    end
endmodule // bhp_fifo

module bhp_port #(
    parameter MEM_CYCLES = `BHP_MEM_CYCLES,
    parameter IRQ_CYCLES = `BHP_IRQ_CYCLES
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // host pins
    input  wire        port_chip_select_n,
    input  wire        host_strobe_n,
    input  wire [1:0]  access_type_select,
    input  wire        host_read_write,
    input  wire        byte_half_identifier,
    input  wire [7:0]  host_data_in,
    output reg  [7:0]  host_data_out,
    output reg         host_data_oe,
    output reg         port_ready_out,
    output reg         processor_to_host_irq_n,
    // processor side
    input  wire        cpu_ctl_wr,
    input  wire [15:0] cpu_ctl_wdata,
    output reg  [15:0] cpu_ctl_rdata,
    output reg         host_to_processor_irq,
    // on-chip ram port
    output reg         ram_req,
    output reg         ram_we,
    output reg  [22:0] ram_addr,
    output reg  [15:0] ram_wdata,
    input  wire        ram_ack,
    input  wire [15:0] ram_rdata
);
    localparam ST_IDLE = 2'd0;
    localparam ST_MEM  = 2'd1;
    localparam ST_IRQ  = 2'd2;

    // pin synchronisers
    reg  [1:0] cs_s1_reg, cs_s2_reg;
    reg  [1:0] stb_s1_reg, stb_s2_reg;
    reg  [1:0] sel_s1_reg, sel_s2_reg;
    reg        rw_s1_reg, rw_s2_reg, half_s1_reg, half_s2_reg;
    reg  [7:0] d_s1_reg, d_s2_reg;
    reg        stb_prev_reg;

    // port state
    reg        byte_order_select_reg;
    reg        extended_address_select_reg;
    reg        host_irq_bit_reg;
    reg [22:0] port_address_reg;
    reg [7:0]  latch_first_reg, latch_second_reg;
    reg [1:0]  state_reg;
    reg [3:0]  cnt_reg;
    reg        mem_done_reg;
    reg        pirq_req_reg;

    // fifo between the port and ram
    wire        fifo_in_ready, fifo_out_valid;
    wire [38:0] fifo_out_data;
    reg         fifo_in_valid;
    reg  [38:0] fifo_in_data;
    reg         fifo_out_ready;

    bhp_fifo #(.WIDTH(39), .DEPTH(32), .AW(5)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // pick the byte to read according to half and order
    function [7:0] pick_byte;
        input       second;
        input       order;
        input [15:0] word;
        begin
            pick_byte = (second ^ order) ? word[7:0] : word[15:8];
        end
    endfunction

    wire        strobe_end = stb_s2_reg[0] & ~stb_prev_reg;    // rising edge of strobe_n
    wire        selected   = ~cs_s2_reg[0];
    wire        second     = half_s2_reg;
    wire [15:0] ctl_view   = {3'b000, extended_address_select_reg, 1'b0, host_irq_bit_reg,
                              1'b0, byte_order_select_reg,
                              3'b000, extended_address_select_reg, 1'b0, host_irq_bit_reg,
                              1'b0, byte_order_select_reg};

    // two-flop synchronisers on every host pin
    always @(posedge clk) begin
        if (!rst_n) begin
            cs_s1_reg <= 2'b11; cs_s2_reg <= 2'b11;
            stb_s1_reg <= 2'b11; stb_s2_reg <= 2'b11;
            sel_s1_reg <= 2'b00; sel_s2_reg <= 2'b00;
            rw_s1_reg <= 1'b1; rw_s2_reg <= 1'b1;
            half_s1_reg <= 1'b0; half_s2_reg <= 1'b0;
            d_s1_reg <= 8'h00; d_s2_reg <= 8'h00;
            stb_prev_reg <= 1'b1;
        end else begin
            cs_s1_reg <= {1'b1, port_chip_select_n}; cs_s2_reg <= cs_s1_reg;
            stb_s1_reg <= {1'b1, host_strobe_n | port_chip_select_n};
            stb_s2_reg <= stb_s1_reg;
            sel_s1_reg <= access_type_select; sel_s2_reg <= sel_s1_reg;
            rw_s1_reg <= host_read_write; rw_s2_reg <= rw_s1_reg;
            half_s1_reg <= byte_half_identifier; half_s2_reg <= half_s1_reg;
            d_s1_reg <= host_data_in; d_s2_reg <= d_s1_reg;
            stb_prev_reg <= stb_s2_reg[0];
        end
    end

    // fifo drain into ram, stalled until ram acknowledges
    always @* begin
        fifo_out_ready = ram_ack & ram_req & ram_we;
    end

    // host accesses, internal transfers and interrupt bits
    always @(posedge clk) begin
        if (!rst_n) begin
            byte_order_select_reg <= 1'b0;
            extended_address_select_reg <= 1'b0;
            host_irq_bit_reg <= 1'b0;
            port_address_reg <= 23'h000000;
            latch_first_reg <= 8'h00;
            latch_second_reg <= 8'h00;
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            mem_done_reg <= 1'b0;
            pirq_req_reg <= 1'b0;
            fifo_in_valid <= 1'b0;
            fifo_in_data <= 39'h0;
            ram_req <= 1'b0;
            ram_we <= 1'b0;
            ram_addr <= 23'h000000;
            ram_wdata <= 16'h0000;
            host_to_processor_irq <= 1'b0;
        end else begin
            fifo_in_valid <= 1'b0;
            host_to_processor_irq <= 1'b0;
            // processor sets host irq; zero writes ignored
            if (cpu_ctl_wr && cpu_ctl_wdata[`BHP_CTL_HIRQ_BIT])
                host_irq_bit_reg <= 1'b1;
            // processor-interrupt bit from processor has no effect
            case (state_reg)
                ST_IDLE: begin
                    if (strobe_end && selected) begin
                        case (sel_s2_reg)
                            `BHP_SEL_CTRL: begin
                                if (!rw_s2_reg) begin
                                    byte_order_select_reg <= d_s2_reg[`BHP_CTL_ORDER_BIT];
                                    extended_address_select_reg <= d_s2_reg[`BHP_CTL_XADDR_BIT];
                                    if (d_s2_reg[`BHP_CTL_HIRQ_BIT] &&
                                        !(cpu_ctl_wr && cpu_ctl_wdata[`BHP_CTL_HIRQ_BIT]))
                                        host_irq_bit_reg <= 1'b0;
                                    if (second && d_s2_reg[`BHP_CTL_PIRQ_BIT])
                                        pirq_req_reg <= 1'b1;
                                    if (d_s2_reg[`BHP_CTL_PIRQ_BIT] ||
                                        d_s2_reg[`BHP_CTL_HIRQ_BIT]) begin
                                        state_reg <= ST_IRQ;
                                        cnt_reg <= 4'h0;
                                    end // plain writes keep ready high
                                end
                            end
                            `BHP_SEL_ADDR: begin
                                if (!rw_s2_reg) begin
                                    if (extended_address_select_reg)
                                        port_address_reg[22:16] <= d_s2_reg[6:0];
                                    else if (second ^ byte_order_select_reg)
                                        port_address_reg[7:0] <= d_s2_reg;
                                    else
                                        port_address_reg[15:8] <= d_s2_reg;
                                    if (second) begin
                                        state_reg <= ST_MEM; // prefetch
                                        ram_we <= 1'b0;
                                        cnt_reg <= 4'h0;
                                        mem_done_reg <= 1'b0;
                                    end
                                end
                            end
                            default: begin
                                if (!rw_s2_reg) begin
                                    if (second)
                                        latch_second_reg <= d_s2_reg;
                                    else
                                        latch_first_reg <= d_s2_reg;
                                end
                                if (second) begin
                                    state_reg <= ST_MEM;
                                    ram_we <= ~rw_s2_reg;
                                    cnt_reg <= 4'h0;
                                    mem_done_reg <= 1'b0;
                                    if (sel_s2_reg == `BHP_SEL_DATA_INC) begin
                                        // once per word, pre on write, post on read
                                        port_address_reg <= port_address_reg + 23'h000001;
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_MEM: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == 4'h0) begin
                        if (ram_we) begin
                            // word queued for ram, both latches as one
                            fifo_in_valid <= fifo_in_ready;
                            fifo_in_data <= {port_address_reg,
                                             latch_first_reg, latch_second_reg};
                            if (!fifo_in_ready)
                                cnt_reg <= 4'h0;
                        end else begin
                            ram_req <= 1'b1;
                            ram_addr <= port_address_reg;
                        end
                    end
                    if (!ram_we && ram_req && ram_ack) begin
                        ram_req <= 1'b0;
                        latch_first_reg <= ram_rdata[15:8];
                        latch_second_reg <= ram_rdata[7:0];
                        mem_done_reg <= 1'b1;
                    end
                    // done only once the queued word has left the fifo and ram took it
                    if (ram_we && cnt_reg != 4'h0 && !fifo_in_valid && !fifo_out_valid &&
                        !ram_req)
                        mem_done_reg <= 1'b1;
                    if (mem_done_reg && cnt_reg >= MEM_CYCLES - 1)
                        state_reg <= ST_IDLE; // at least five clocks
                end
                ST_IRQ: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (pirq_req_reg) begin
                        host_to_processor_irq <= 1'b1; // pulse for flag bit nine, vector 64h
                        pirq_req_reg <= 1'b0;
                    end
                    if (cnt_reg >= IRQ_CYCLES - 1)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
            // ram write port fed from the fifo
            if (fifo_out_valid && !ram_req) begin
                ram_req <= 1'b1;
                ram_we <= 1'b1;
                ram_addr <= fifo_out_data[38:16];
                ram_wdata <= fifo_out_data[15:0];
            end else if (ram_we && ram_req && ram_ack) begin
                ram_req <= 1'b0;
            end
        end
    end

    // registered pin outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
            port_ready_out <= 1'b1;
            processor_to_host_irq_n <= 1'b1;
            cpu_ctl_rdata <= 16'h0000;
        end else begin
            host_data_oe <= selected & ~stb_s2_reg[0] & rw_s2_reg;
            case (sel_s2_reg)
                `BHP_SEL_CTRL: host_data_out <= pick_byte(second, 1'b0, ctl_view);
                `BHP_SEL_ADDR: host_data_out <= pick_byte(second, byte_order_select_reg,
                                                          port_address_reg[15:0]);
                default:       host_data_out <= second ? latch_second_reg
                                                       : latch_first_reg;
            endcase
            // low during internal work, always high when not selected
            port_ready_out <= ~selected | (state_reg == ST_IDLE);
            processor_to_host_irq_n <= ~host_irq_bit_reg;
            cpu_ctl_rdata <= ctl_view; // processor-interrupt bit reads zero
        end
    end
endmodule // bhp_port
`default_nettype wire

//--- src/bhp_map.vh
`ifndef BHP_MAP_VH
`define BHP_MAP_VH
`define BHP_SEL_CTRL      2'b00
`define BHP_SEL_DATA_INC  2'b01
`define BHP_SEL_ADDR      2'b10
`define BHP_SEL_DATA      2'b11
`define BHP_CTL_ORDER_BIT 0
`define BHP_CTL_PIRQ_BIT  1
`define BHP_CTL_HIRQ_BIT  2
`define BHP_CTL_XADDR_BIT 4
`define BHP_PIRQ_VECTOR   8'h64
`define BHP_PIRQ_FLAG_BIT 9
`define BHP_MEM_CYCLES    5
`define BHP_IRQ_CYCLES    3
`define BHP_ADDR_W        23
`endif

//--- verif/bhp_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bhp_port_asserts #(
    parameter MEM_CYCLES = 5,
    parameter IRQ_CYCLES = 3
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // host pins
    input wire logic        port_chip_select_n,
    input wire logic        host_strobe_n,
    input wire logic [1:0]  access_type_select,
    input wire logic        host_read_write,
    input wire logic [7:0]  host_data_in,
    input wire logic        port_ready_out,
    input wire logic        processor_to_host_irq_n,
    // processor side and ram port
    input wire logic        cpu_ctl_wr,
    input wire logic [15:0] cpu_ctl_wdata,
    input wire logic [15:0] cpu_ctl_rdata,
    input wire logic        host_to_processor_irq,
    input wire logic        ram_req,
    input wire logic        ram_we,
    input wire logic [22:0] ram_addr,
    input wire logic        ram_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] low_cnt;
    logic       saw_rd;
    logic [3:0] cpu_age;
    logic [4:0] ctl_age;
    logic       stb_q;
    // length of each ready-low stretch, ram reads inside it, ages of irq causes
    always @(posedge clk) begin
        stb_q <= host_strobe_n;
        if (!rst_n) begin
            low_cnt <= 4'h0;
            saw_rd  <= 1'b0;
            cpu_age <= 4'hf;
            ctl_age <= 5'h1f;
        end else begin
            low_cnt <= port_ready_out ? 4'h0 : (low_cnt == 4'hf ? low_cnt : low_cnt + 4'h1);
            saw_rd  <= !port_ready_out && (saw_rd || (ram_req && ram_ack && !ram_we));
            cpu_age <= (cpu_ctl_wr && cpu_ctl_wdata[2]) ? 4'h0 : (cpu_age == 4'hf ? cpu_age : cpu_age + 4'h1);
            ctl_age <= (host_strobe_n && !stb_q && !port_chip_select_n && access_type_select == 2'b00
                        && !host_read_write && host_data_in[1]) ? 5'h0
                       : (ctl_age == 5'h1f ? ctl_age : ctl_age + 5'h1);
        end
    end
    property p_desel_rdy;
        port_chip_select_n [*4] |-> port_ready_out;
    endproperty
    a_desel_rdy: assert property (p_desel_rdy) else $error("ready low while deselected");
    property p_busy_min;
        $fell(port_ready_out) |-> !port_ready_out [*3];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("ready low too short");
    property p_mem_len;
        $rose(port_ready_out) && saw_rd |-> low_cnt >= MEM_CYCLES;
    endproperty
    a_mem_len: assert property (p_mem_len) else $error("memory transfer too short");
    property p_rd_busy;
        ram_req && !ram_we |-> !port_ready_out;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("ready high during ram read");
    property p_req_hold;
        ram_req && !ram_ack |=> ram_req && $stable(ram_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("ram request dropped");
    property p_hirq_set;
        cpu_ctl_wr && cpu_ctl_wdata[2] |-> ##[1:4] (!processor_to_host_irq_n && cpu_ctl_rdata[2]);
    endproperty
    a_hirq_set: assert property (p_hirq_set) else $error("host irq not raised");
    property p_hirq_cause;
        $fell(processor_to_host_irq_n) |-> cpu_age <= 4'h4;
    endproperty
    a_hirq_cause: assert property (p_hirq_cause) else $error("host irq without cause");
    property p_pirq_zero;
        cpu_ctl_rdata[1] == 1'b0;
    endproperty
    a_pirq_zero: assert property (p_pirq_zero) else $error("processor irq bit reads one");
    property p_pirq_pulse;
        host_to_processor_irq |=> !host_to_processor_irq;
    endproperty
    a_pirq_pulse: assert property (p_pirq_pulse) else $error("processor irq too long");
    property p_pirq_cause;
        host_to_processor_irq |-> ctl_age <= 5'hc;
    endproperty
    a_pirq_cause: assert property (p_pirq_cause) else $error("processor irq without cause");
    property p_fast_rdy;
        host_strobe_n && !stb_q && !port_chip_select_n && port_ready_out &&
        (host_read_write ? !access_type_select[0]
                         : (access_type_select == 2'b00 && host_data_in[2:1] == 2'b00))
        |-> port_ready_out [*6];
    endproperty
    a_fast_rdy: assert property (p_fast_rdy) else $error("ready low on register access");
    c_mem: cover property ($rose(port_ready_out) && saw_rd);
    c_pirq: cover property (host_to_processor_irq);
    c_hirq: cover property ($fell(processor_to_host_irq_n));
endmodule // bhp_port_asserts
`default_nettype wire

//--- verif/bhp_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module bhp_ram_model (
    // clock, reset and pace
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        slow,
    // request side
    input wire logic        ram_req,
    input wire logic        ram_we,
    input wire logic [22:0] ram_addr,
    input wire logic [15:0] ram_wdata,
    output var logic        ram_ack,
    output var logic [15:0] ram_rdata
);
    logic [15:0] mem [0:255];
    logic [2:0]  wait_cnt;
    integer      i;
    // each word starts as its index and the index inverted
    initial for (i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
    // answers after one or six cycles; read data is only valid with ack
    always @(posedge clk) begin
        if (!rst_n) begin
            ram_ack   <= 1'b0;
            wait_cnt  <= 3'h0;
            ram_rdata <= 16'ha5a5;
        end else if (ram_ack || !ram_req) begin
            ram_ack   <= 1'b0;
            wait_cnt  <= 3'h0;
            ram_rdata <= ~ram_rdata; // released bus keeps toggling
        end else if (wait_cnt >= (slow ? 3'h5 : 3'h0)) begin
            ram_ack <= 1'b1;
            if (ram_we) mem[ram_addr[7:0]] <= ram_wdata;
            else ram_rdata <= mem[ram_addr[7:0]];
        end else begin
            wait_cnt  <= wait_cnt + 3'h1;
            ram_rdata <= ~ram_rdata;
        end
    end
endmodule // bhp_ram_model
`default_nettype wire

//--- verif/test_byte_host_port_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_byte_host_port_access;
    // clock, reset and host pins
    logic clk, rst_n, port_chip_select_n, host_strobe_n, host_read_write, byte_half_identifier;
    logic [1:0]  access_type_select;
    logic [7:0]  host_data_in, host_data_out;
    logic        host_data_oe, port_ready_out, processor_to_host_irq_n;
    // processor side and ram port
    logic        cpu_ctl_wr, host_to_processor_irq, ram_req, ram_we, ram_ack, slow;
    logic [15:0] cpu_ctl_wdata, cpu_ctl_rdata, ram_wdata, ram_rdata, base;
    logic [22:0] ram_addr;
    // expectation notes and counters
    logic [39:0] ram_q[$];
    logic [7:0]  byte_q[$];
    logic [39:0] e_ram;
    logic [15:0] wr [0:4];
    integer      n_mismatch, samples_checked, n_pirq, cycles, seed, k;

    bhp_port bhp_port_i (.clk, .rst_n, .port_chip_select_n, .host_strobe_n, .access_type_select,
        .host_read_write, .byte_half_identifier, .host_data_in, .host_data_out, .host_data_oe,
        .port_ready_out, .processor_to_host_irq_n, .cpu_ctl_wr, .cpu_ctl_wdata, .cpu_ctl_rdata,
        .host_to_processor_irq, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack, .ram_rdata);
    bhp_ram_model bhp_ram_model_i (.clk, .rst_n, .slow, .ram_req, .ram_we, .ram_addr,
        .ram_wdata, .ram_ack, .ram_rdata);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic fail(input string m);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic cmp_ram(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got[39:16] !== exp[39:16] || (exp[39] && got[15:0] !== exp[15:0])) fail("ram cycle");
    endtask
    task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) fail("read byte");
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) fail("flag");
    endtask
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ram watcher: oldest note against each finished ram cycle
    always @(posedge clk) if (ram_req === 1'b1 && ram_ack === 1'b1) begin
        if (ram_q.size() == 0) fail("unexpected ram cycle");
        else begin
            e_ram = ram_q.pop_front();
            cmp_ram({ram_we, ram_addr, ram_wdata}, e_ram);
        end
    end
    // byte watcher: read byte taken as the strobe is released
    always @(posedge host_strobe_n) if (host_read_write === 1'b1)
        cmp_byte({host_data_oe, host_data_out}, {1'b1, byte_q.pop_front()});
    // processor interrupt pulses and hang guard
    always @(posedge clk) begin
        if (host_to_processor_irq === 1'b1) n_pirq++;
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            wrap_up();
        end
    end
    task host_byte(input logic [1:0] s, input logic r, input logic h, input logic [7:0] d);
        integer i;
        @(negedge clk);
        access_type_select = s;
        host_read_write = r;
        byte_half_identifier = h;
        host_data_in = d;
        host_strobe_n = 1'b0;
        repeat (6) @(negedge clk);
        host_strobe_n = 1'b1;
        repeat (8) @(negedge clk);
        i = 0;
        while (port_ready_out !== 1'b1 && i < 200) begin
            @(negedge clk);
            i++;
        end
        if (i == 200) fail("ready stuck");
    endtask
    task wr_word(input logic [1:0] s, input logic [15:0] v); // first byte is high byte
        host_byte(s, 1'b0, 1'b0, v[15:8]);
        host_byte(s, 1'b0, 1'b1, v[7:0]);
    endtask
    task rd_word(input logic [1:0] s, input logic [15:0] v);
        byte_q.push_back(v[15:8]);
        byte_q.push_back(v[7:0]);
        host_byte(s, 1'b1, 1'b0, 8'h00);
        host_byte(s, 1'b1, 1'b1, 8'h00);
    endtask
    task cpu_wr(input logic [15:0] v);
        @(negedge clk);
        cpu_ctl_wr = 1'b1;
        cpu_ctl_wdata = v;
        @(negedge clk);
        cpu_ctl_wr = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    function automatic logic [39:0] rd_at(input logic [15:0] a);
        rd_at = {1'b0, 7'h05, a, 16'h0000};
    endfunction
    function automatic logic [15:0] mw(input logic [7:0] a);
        mw = {a, ~a};
    endfunction
    // main sequence
    initial begin
        seed = 32'h9ec2;
        {n_mismatch, samples_checked, n_pirq, cycles} = '0;
        {rst_n, host_read_write, byte_half_identifier, cpu_ctl_wr, slow} = '0;
        {port_chip_select_n, host_strobe_n} = 2'b11;
        {access_type_select, host_data_in, cpu_ctl_wdata} = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        port_chip_select_n = 1'b0;
        repeat (4) @(negedge clk);
        base = 16'($random(seed)) & 16'h00f0;
        wr_word(2'b00, 16'h0000);
        ram_q.push_back({1'b0, 7'h00, base, 16'h0000});
        wr_word(2'b10, base);
        wr_word(2'b00, 16'h1010);
        rd_word(2'b00, 16'h1010);
        ram_q.push_back(rd_at(base));
        wr_word(2'b10, 16'h0505);
        wr_word(2'b00, 16'h0000);
        base = 16'($random(seed)) & 16'h00f0;
        ram_q.push_back(rd_at(base));
        wr_word(2'b10, base);
        for (k = 0; k < 2; k++) begin
            ram_q.push_back(rd_at(16'(base + k + 1)));
            rd_word(2'b01, mw(8'(base + k)));
        end
        for (k = 0; k < 4; k++) begin
            wr[k] = 16'($random(seed));
            slow = k[0];
            ram_q.push_back({1'b1, 7'h05, 16'(base + k + 3), wr[k]});
            wr_word(2'b01, wr[k]);
        end
        wr[4] = 16'($random(seed));
        ram_q.push_back({1'b1, 7'h05, 16'(base + 6), wr[4]});
        wr_word(2'b11, wr[4]);
        ram_q.push_back(rd_at(16'(base + 4)));
        wr_word(2'b10, 16'(base + 4));
        for (k = 1; k < 4; k++) begin
            ram_q.push_back(rd_at(16'(base + k + 4)));
            rd_word(2'b01, (k == 3) ? wr[4] : wr[k]);
        end
        wr_word(2'b00, 16'h0202);
        cmp_flag(n_pirq == 1, 1'b1);
        cmp_flag(cpu_ctl_rdata[1], 1'b0);
        wr_word(2'b00, 16'h0000);
        cpu_wr(16'h0002);
        cmp_flag(n_pirq == 1, 1'b1);
        wr_word(2'b00, 16'h0202);
        cmp_flag(n_pirq == 2, 1'b1);
        cpu_wr(16'h0004);
        cmp_flag(processor_to_host_irq_n, 1'b0);
        cmp_flag(cpu_ctl_rdata[2], 1'b1);
        cpu_wr(16'h0000);
        wr_word(2'b00, 16'h0000);
        cmp_flag(processor_to_host_irq_n, 1'b0);
        wr_word(2'b00, 16'h0404);
        cmp_flag(processor_to_host_irq_n, 1'b1);
        cmp_flag(cpu_ctl_rdata[2], 1'b0);
        port_chip_select_n = 1'b1;
        repeat (10) @(negedge clk);
        cmp_flag(port_ready_out, 1'b1);
        cmp_flag(ram_q.size() == 0, 1'b1);
        wrap_up();
    end
endmodule // test_byte_host_port_access
bind bhp_port bhp_port_asserts #(.MEM_CYCLES(MEM_CYCLES), .IRQ_CYCLES(IRQ_CYCLES))
    bhp_port_asserts_i (.clk, .rst_n, .port_chip_select_n, .host_strobe_n, .access_type_select,
    .host_read_write, .host_data_in, .port_ready_out, .processor_to_host_irq_n, .cpu_ctl_wr,
    .cpu_ctl_wdata, .cpu_ctl_rdata, .host_to_processor_irq, .ram_req, .ram_we, .ram_addr,
    .ram_ack);
`default_nettype wire
